// file: verilog/cwd_defs.svh
/*
 * constants of the configuration word decoder: word indices, field
 * positions, register offsets and bit masks.
 * assumes nothing; definitions only.
 */
`ifndef CWD_DEFS_SVH
`define CWD_DEFS_SVH

`define CWD_NUM_WORDS 9
`define CWD_WORD_W 24
`define CWD_IDX_W 4
// word index order used by the loader
`define CWD_W_SEC 4'h0
`define CWD_W_BOOT_PAGE_LIMIT 4'h1
`define CWD_W_OSCSEL 4'h2
`define CWD_W_OSC 4'h3
`define CWD_W_CNTL 4'h4
`define CWD_W_CNTH 4'h5
`define CWD_W_DMT 4'h6
`define CWD_W_DEVOPT 4'h7
`define CWD_W_ALTREG 4'h8
// register offsets on the software port
`define CWD_ADDR_W 24
`define CWD_OFS_SEC 24'h015780
`define CWD_OFS_BOOT_PAGE_LIMIT 24'h015790
`define CWD_OFS_OSCSEL 24'h015798
`define CWD_OFS_OSC 24'h01579C
`define CWD_OFS_CNTL 24'h0157B4
`define CWD_OFS_CNTH 24'h0157B8
`define CWD_OFS_DMT 24'h0157BC
`define CWD_OFS_DEVOPT 24'h0157C0
`define CWD_OFS_ALTREG 24'h0157C4
`define CWD_OFS_STATUS 24'h0157D0
// implemented bit masks; all other bits read as one
`define CWD_MASK_SEC 24'h00B3FF
`define CWD_MASK_BOOT_PAGE_LIMIT 24'h001FFF
`define CWD_MASK_OSCSEL 24'h000087
`define CWD_MASK_OSC 24'h000003
`define CWD_MASK_CNT 24'h00FFFF
`define CWD_MASK_DMT 24'h000001
`define CWD_MASK_DEVOPT 24'h00000D
`define CWD_MASK_ALTREG 24'h000077
// field positions in the code security, oscillator select and device option words
`define CWD_SEC_BOOT_WRITE_PROTECT_N 0
`define CWD_SEC_BSS_LO 1
`define CWD_SEC_BOOT_SEGMENT_ABSENT 3
`define CWD_SEC_GENERAL_WRITE_PROTECT_N 4
`define CWD_SEC_GSS_LO 5
`define CWD_SEC_CONFIG_WRITE_PROTECT_N 7
`define CWD_SEC_CSS_LO 8
`define CWD_SEC_ALT_VECTOR_TABLE_DISABLE 15
`define CWD_OSCSEL_TWO_SPEED_STARTUP 7
`define CWD_DEVOPT_RSVD 2
// field widths
`define CWD_PAGE_W 13
`define CWD_CNT_HALF_W 16

`endif

// file: verilog/cwd_pkg.sv
/*
 * types of the configuration word decoder.
 * needs nothing from cwd_defs.svh; types only.
 */
package cwd_pkg;
    typedef enum logic [1:0] {
        CWD_SEC_NONE,
        CWD_SEC_STANDARD,
        CWD_SEC_ENHANCED,
        CWD_SEC_HIGH
    } cwd_sec_level_t;

    typedef enum logic [2:0] {
        CWD_OSC_FAST_RC,
        CWD_OSC_FAST_RC_PLL,
        CWD_OSC_PRIMARY,
        CWD_OSC_PRIMARY_PLL,
        CWD_OSC_RESERVED,
        CWD_OSC_LOW_POWER_RC,
        CWD_OSC_FAST_RC_DIV16,
        CWD_OSC_FAST_RC_POST
    } cwd_osc_src_t;

    typedef enum logic [1:0] {
        CWD_POSC_EXT_CLOCK,
        CWD_POSC_STD_CRYSTAL,
        CWD_POSC_HS_CRYSTAL,
        CWD_POSC_OFF
    } cwd_posc_mode_t;

    typedef enum logic [1:0] {
        CWD_LOAD_REQ,
        CWD_LOAD_WAIT,
        CWD_LOAD_DONE
    } cwd_load_state_t;
endpackage : cwd_pkg

// file: verilog/cwd_config_decoder.sv
/*
 * configuration word decoder: copies the nonvolatile configuration words
 * into holding registers after reset, decodes them into settings and
 * serves them read-only on a plain software port.
 * assumes a configuration memory that answers a word request with
 * nvm_valid some cycles later, on the same clock; nvm_req is ours.
 */
// Behaviour
// - unimplemented configuration bits read as one
// - boot write-protect zero blocks boot writes
// - boot level: 11 none, 10 std, 0x high
// - boot segment absent when control bit set
// - general write-protect zero blocks user writes
// - general protection level decode like boot
// - config write-protect zero blocks config writes
// - config level: 111 none,110 std,10x enhanced,0xx high
// - alternate vector table disabled when bit one
// - page limit holds inverted first general page
// - three-bit initial oscillator source decode
// - two-speed start on fast RC, then switch
// - primary oscillator mode two-bit decode
// - deadman count is 32 bits from two words
// - deadman enable one: on, software cannot stop
`include "cwd_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module cwd_config_decoder
(
    input wire logic clk,
    input wire logic rst_n,
    // configuration memory side
    output logic nvm_req,
    output logic [`CWD_IDX_W-1:0] nvm_index,
    input wire logic nvm_valid,
    input wire logic [`CWD_WORD_W-1:0] nvm_data,
    // software port
    input wire logic [`CWD_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // decoded settings
    output logic config_ready,
    output logic boot_write_block,
    output cwd_pkg::cwd_sec_level_t boot_protect_level,
    output logic boot_segment_absent,
    output logic [`CWD_PAGE_W-1:0] boot_page_limit,
    output logic [`CWD_PAGE_W-1:0] first_general_page,
    output logic general_write_block,
    output cwd_pkg::cwd_sec_level_t general_protect_level,
    output logic config_write_block,
    output cwd_pkg::cwd_sec_level_t config_protect_level,
    output logic alt_vector_table_enable,
    output cwd_pkg::cwd_osc_src_t initial_osc_select,
    output logic two_speed_startup,
    output cwd_pkg::cwd_osc_src_t startup_osc_select,
    output cwd_pkg::cwd_posc_mode_t primary_osc_mode,
    output logic [2*`CWD_CNT_HALF_W-1:0] deadman_instr_count,
    output logic deadman_enable,
    output logic deadman_sw_disable_locked,
    output logic device_option_reserved_ok,
    input wire logic osc_selected_ready
);
    import cwd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        cwd_load_state_t st;
        logic [`CWD_IDX_W-1:0] idx;
        logic req;
        logic [`CWD_NUM_WORDS-1:0][`CWD_WORD_W-1:0] words;
        logic ready;
        logic on_fast_rc;
        logic boot_wb;
        cwd_sec_level_t boot_lvl;
        logic boot_abs;
        logic [`CWD_PAGE_W-1:0] page_lim;
        logic [`CWD_PAGE_W-1:0] first_gen;
        logic gen_wb;
        cwd_sec_level_t gen_lvl;
        logic cfg_wb;
        cwd_sec_level_t cfg_lvl;
        logic alt_vector_table_en;
        cwd_osc_src_t osc_sel;
        logic two_speed;
        cwd_osc_src_t start_osc;
        cwd_posc_mode_t posc;
        logic [2*`CWD_CNT_HALF_W-1:0] dmt_cnt;
        logic dmt_en;
        logic rsvd_ok;
        logic [31:0] rdata;
    } cwd_state_t;

    cwd_state_t s_q;
    cwd_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // two-bit level: 11 none, 10 standard, 0x high
    function automatic cwd_sec_level_t level2(input logic [1:0] v);
        cwd_sec_level_t r;
        if (v == 2'h3)
            r = CWD_SEC_NONE;
        else if (v == 2'h2)
            r = CWD_SEC_STANDARD;
        else
            r = CWD_SEC_HIGH;
        return r;
    endfunction

    // three-bit level: 111 none, 110 standard, 10x enhanced, 0xx high
    function automatic cwd_sec_level_t level3(input logic [2:0] v);
        cwd_sec_level_t r;
        if (v == 3'h7)
            r = CWD_SEC_NONE;
        else if (v == 3'h6)
            r = CWD_SEC_STANDARD;
        else if (v[2])
            r = CWD_SEC_ENHANCED;
        else
            r = CWD_SEC_HIGH;
        return r;
    endfunction

    // implemented bits pass, the rest read as one
    function automatic logic [`CWD_WORD_W-1:0] fill(
        input logic [`CWD_WORD_W-1:0] w,
        input logic [`CWD_WORD_W-1:0] m);
        return (w & m) | ~m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // readback views of the held words

    // implemented-bit masks in word index order, index 0 rightmost
    localparam logic [`CWD_NUM_WORDS-1:0][`CWD_WORD_W-1:0] word_masks = {
        `CWD_MASK_ALTREG,
        `CWD_MASK_DEVOPT,
        `CWD_MASK_DMT,
        `CWD_MASK_CNT,
        `CWD_MASK_CNT,
        `CWD_MASK_OSC,
        `CWD_MASK_OSCSEL,
        `CWD_MASK_BOOT_PAGE_LIMIT,
        `CWD_MASK_SEC
    };

    logic [`CWD_WORD_W-1:0] view [`CWD_NUM_WORDS];

    // one masked view per held word; the port only selects among them
    for (genvar i = 0; i < `CWD_NUM_WORDS; i++)
    begin : g_view
        assign view[i] = fill(s_q.words[i], word_masks[i]);
    end

    ////////////////////////////////////////////////////////////////////////
    // loader, decoder and register port

    logic [`CWD_WORD_W-1:0] sec_w;
    logic [`CWD_WORD_W-1:0] boot_page_limit_w;
    logic [`CWD_WORD_W-1:0] oscsel_w;
    logic [`CWD_WORD_W-1:0] osc_w;
    logic [`CWD_WORD_W-1:0] status_w;
    logic [`CWD_WORD_W-1:0] rd_word;
    logic rd_hit;

    always_comb
    begin
        s_d = s_q;
        sec_w = s_q.words[`CWD_W_SEC];
        boot_page_limit_w = s_q.words[`CWD_W_BOOT_PAGE_LIMIT];
        oscsel_w = s_q.words[`CWD_W_OSCSEL];
        osc_w = s_q.words[`CWD_W_OSC];

        // load every word once; the held words do not change afterwards until reset
        case (s_q.st)
            CWD_LOAD_REQ:
            begin
                // one-cycle request for the word at idx
                s_d.req = 1'b1;
                s_d.st = CWD_LOAD_WAIT;
            end
            CWD_LOAD_WAIT:
            begin
                // a valid pulse in any other state is ignored
                s_d.req = 1'b0;
                if (nvm_valid)
                begin
                    s_d.words[s_q.idx] = nvm_data;
                    if (s_q.idx == 4'(`CWD_NUM_WORDS - 1))
                        s_d.st = CWD_LOAD_DONE;
                    else
                    begin
                        s_d.idx = s_q.idx + 4'h1;
                        s_d.st = CWD_LOAD_REQ;
                    end
                end
            end
            CWD_LOAD_DONE:
            begin
                // ready rises together with the frozen settings
                s_d.req = 1'b0;
                s_d.ready = 1'b1;
            end
            default:
                s_d.st = CWD_LOAD_REQ;
        endcase

        // settings decoded from the held words once, when loading is done; frozen after
        if (s_q.st == CWD_LOAD_DONE && !s_q.ready)
        begin
            // code protection
            s_d.boot_wb = ~sec_w[`CWD_SEC_BOOT_WRITE_PROTECT_N];
            s_d.boot_lvl = level2(sec_w[`CWD_SEC_BSS_LO +: 2]);
            s_d.boot_abs = sec_w[`CWD_SEC_BOOT_SEGMENT_ABSENT];
            s_d.page_lim = boot_page_limit_w[`CWD_PAGE_W-1:0];
            // stored inverted: more zeros only grow the boot segment
            s_d.first_gen = s_d.boot_abs ? '0 :
                ~boot_page_limit_w[`CWD_PAGE_W-1:0];
            s_d.gen_wb = ~sec_w[`CWD_SEC_GENERAL_WRITE_PROTECT_N];
            s_d.gen_lvl = level2(sec_w[`CWD_SEC_GSS_LO +: 2]);
            s_d.cfg_wb = ~sec_w[`CWD_SEC_CONFIG_WRITE_PROTECT_N];
            s_d.cfg_lvl = level3(sec_w[`CWD_SEC_CSS_LO +: 3]);
            s_d.alt_vector_table_en = ~sec_w[`CWD_SEC_ALT_VECTOR_TABLE_DISABLE];
            // oscillator start-up
            s_d.osc_sel = cwd_osc_src_t'(oscsel_w[2:0]);
            s_d.two_speed = oscsel_w[`CWD_OSCSEL_TWO_SPEED_STARTUP];
            s_d.on_fast_rc = s_d.two_speed;
            s_d.posc = cwd_posc_mode_t'(osc_w[1:0]);
            // deadman timer and device option
            s_d.dmt_cnt = {s_q.words[`CWD_W_CNTH][`CWD_CNT_HALF_W-1:0],
                s_q.words[`CWD_W_CNTL][`CWD_CNT_HALF_W-1:0]};
            s_d.dmt_en = s_q.words[`CWD_W_DMT][0];
            s_d.rsvd_ok =
                s_q.words[`CWD_W_DEVOPT][`CWD_DEVOPT_RSVD];
        end

        // two-speed start: fast RC until the selected source is ready
        if (s_q.ready && s_q.on_fast_rc && osc_selected_ready)
            s_d.on_fast_rc = 1'b0;
        s_d.start_osc = s_d.on_fast_rc ? CWD_OSC_FAST_RC : s_d.osc_sel;

        // status: bit 0 loaded, bits 4:1 word index, bit 5 reserved bit
        // ok, bit 6 still running on the fast RC clock
        status_w = {17'h00000, s_q.on_fast_rc, s_q.rsvd_ok, s_q.idx,
            s_q.ready};

        // read-only port; writes are ignored
        rd_hit = 1'b1;
        if (reg_addr == `CWD_OFS_SEC)
            rd_word = view[`CWD_W_SEC];
        else if (reg_addr == `CWD_OFS_BOOT_PAGE_LIMIT)
            rd_word = view[`CWD_W_BOOT_PAGE_LIMIT];
        else if (reg_addr == `CWD_OFS_OSCSEL)
            rd_word = view[`CWD_W_OSCSEL];
        else if (reg_addr == `CWD_OFS_OSC)
            rd_word = view[`CWD_W_OSC];
        else if (reg_addr == `CWD_OFS_CNTL)
            rd_word = view[`CWD_W_CNTL];
        else if (reg_addr == `CWD_OFS_CNTH)
            rd_word = view[`CWD_W_CNTH];
        else if (reg_addr == `CWD_OFS_DMT)
            rd_word = view[`CWD_W_DMT];
        else if (reg_addr == `CWD_OFS_DEVOPT)
            rd_word = view[`CWD_W_DEVOPT];
        else if (reg_addr == `CWD_OFS_ALTREG)
            rd_word = view[`CWD_W_ALTREG];
        else if (reg_addr == `CWD_OFS_STATUS)
            rd_word = status_w;
        else
        begin
            rd_word = '0;
            rd_hit = 1'b0;
        end
        s_d.rdata = '0;
        if (reg_rd && rd_hit)
            s_d.rdata = {8'h00, rd_word};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // until loaded, fail safe: writes blocked, high security
            s_q <= '0;
            s_q.words <= '1;
            s_q.boot_wb <= 1'b1;
            s_q.gen_wb <= 1'b1;
            s_q.cfg_wb <= 1'b1;
            s_q.boot_abs <= 1'b1;
            s_q.boot_lvl <= CWD_SEC_HIGH;
            s_q.gen_lvl <= CWD_SEC_HIGH;
            s_q.cfg_lvl <= CWD_SEC_HIGH;
            s_q.start_osc <= CWD_OSC_FAST_RC;
            s_q.posc <= CWD_POSC_OFF;
        end
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // configuration memory side
    assign nvm_req = s_q.req;
    assign nvm_index = s_q.idx;

    // software port
    assign reg_rdata = s_q.rdata;

    // decoded settings
    assign config_ready = s_q.ready;
    assign boot_write_block = s_q.boot_wb;
    assign boot_protect_level = s_q.boot_lvl;
    assign boot_segment_absent = s_q.boot_abs;
    assign boot_page_limit = s_q.page_lim;
    assign first_general_page = s_q.first_gen;
    assign general_write_block = s_q.gen_wb;
    assign general_protect_level = s_q.gen_lvl;
    assign config_write_block = s_q.cfg_wb;
    assign config_protect_level = s_q.cfg_lvl;
    assign alt_vector_table_enable = s_q.alt_vector_table_en;
    assign initial_osc_select = s_q.osc_sel;
    assign two_speed_startup = s_q.two_speed;
    assign startup_osc_select = s_q.start_osc;
    assign primary_osc_mode = s_q.posc;
    assign deadman_instr_count = s_q.dmt_cnt;
    assign deadman_enable = s_q.dmt_en;
    // software disable stays locked while the timer is forced on
    assign deadman_sw_disable_locked = s_q.dmt_en;
    assign device_option_reserved_ok = s_q.rsvd_ok;

    // writes are accepted and dropped: every word is read only
    logic unused_wr;
    assign unused_wr = reg_wr ^ (|reg_wdata);
endmodule // cwd_config_decoder

`default_nettype wire

// file: verif/cwd_nvm_model.sv
/*
 * configuration memory model: answers each word request after a set
 * latency. assumes the decoder's request port on the same clock.
 */
`include "cwd_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module cwd_nvm_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic nvm_req,
    input wire logic [`CWD_IDX_W-1:0] nvm_index,
    output logic nvm_valid,
    output logic [`CWD_WORD_W-1:0] nvm_data,
    input wire logic [`CWD_WORD_W-1:0] words [`CWD_NUM_WORDS],
    input wire logic [3:0] latency
);
    logic [`CWD_IDX_W-1:0] idx;
    logic [3:0] cnt;
    // data toggles whenever not valid, so stale words never look good
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nvm_valid <= 1'b0;
            nvm_data <= 24'h5A5A5A;
            cnt <= 4'h0;
            idx <= '0;
        end
        else
        begin
            nvm_valid <= 1'b0;
            nvm_data <= ~nvm_data;
            if (nvm_req)
            begin
                idx <= nvm_index;
                cnt <= latency;
            end
            else if (cnt != 4'h0)
            begin
                cnt <= cnt - 4'h1;
                if (cnt == 4'h1)
                begin
                    nvm_valid <= 1'b1;
                    nvm_data <= words[idx];
                end
            end
        end
    end
endmodule // cwd_nvm_model
`default_nettype wire

// file: verif/cwd_config_decoder_asserts.sv
/*
 * port checker of the configuration word decoder.
 * assumes the decoder top module; bound below.
 */
`include "cwd_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module cwd_config_decoder_asserts
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic nvm_req,
    input wire logic [`CWD_IDX_W-1:0] nvm_index,
    input wire logic nvm_valid,
    input wire logic [`CWD_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic config_ready,
    input wire logic boot_segment_absent,
    input wire logic [`CWD_PAGE_W-1:0] boot_page_limit,
    input wire logic [`CWD_PAGE_W-1:0] first_general_page,
    input wire logic two_speed_startup,
    input wire cwd_pkg::cwd_osc_src_t initial_osc_select,
    input wire cwd_pkg::cwd_osc_src_t startup_osc_select,
    input wire logic osc_selected_ready,
    input wire logic [2*`CWD_CNT_HALF_W-1:0] deadman_instr_count,
    input wire logic deadman_enable,
    input wire logic deadman_sw_disable_locked
);
    import cwd_pkg::*;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_word_taken;
        !config_ready && !nvm_req && nvm_valid && nvm_index != 4'h8;
    endsequence
    sequence s_last_taken;
        !config_ready && !nvm_req && nvm_valid && nvm_index == 4'h8;
    endsequence
    a_ready_stays_high: assert property
        (config_ready |=> config_ready)
        else $error("ready dropped without reset");
    a_settings_frozen: assert property (config_ready |=>
        $stable(deadman_instr_count) && $stable(boot_page_limit)
        && $stable(initial_osc_select)) else $error("settings changed");
    a_page_link: assert property (config_ready |->
        first_general_page ==
        (boot_segment_absent ? 13'h0000 : ~boot_page_limit))
        else $error("first general page wrong");
    a_deadman_lock: assert property
        (deadman_enable == deadman_sw_disable_locked)
        else $error("deadman lock differs from enable");
    a_deadman_stays: assert property
        (deadman_sw_disable_locked |=> deadman_sw_disable_locked)
        else $error("deadman lock released without reset");
    a_two_speed: assert property (config_ready ##1 config_ready |->
        startup_osc_select == ((two_speed_startup && !$past(osc_selected_ready))
        ? CWD_OSC_FAST_RC : initial_osc_select))
        else $error("start-up osc wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 24'h0157C8
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_req_pulse: assert property (nvm_req |=> !nvm_req)
        else $error("request longer than one cycle");
    a_next_word: assert property (s_word_taken |=> ##[0:1] nvm_req)
        else $error("next word not requested");
    a_load_done: assert property
        (s_last_taken |-> ##[1:3] config_ready)
        else $error("ready late after last word");
endmodule // cwd_config_decoder_asserts
bind cwd_config_decoder cwd_config_decoder_asserts i_cwd_config_decoder_asserts
(
    .clk, .rst_n, .nvm_req, .nvm_index, .nvm_valid, .reg_addr, .reg_rd,
    .reg_rdata, .config_ready, .boot_segment_absent, .boot_page_limit,
    .first_general_page, .two_speed_startup, .initial_osc_select,
    .startup_osc_select, .osc_selected_ready, .deadman_instr_count,
    .deadman_enable, .deadman_sw_disable_locked
);
`default_nettype wire

// file: verif/test_cwd_config_decoder.sv
/*
 * testbench of the configuration word decoder: eight load runs.
 * assumes the decoder, the memory model and the checker.
 */
`include "cwd_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module test_cwd_config_decoder;
    import cwd_pkg::*;
    logic clk, nvm_req, nvm_valid, reg_wr, reg_rd, config_ready;
    logic rst_n = 1'b0;
    logic osc_selected_ready = 1'b0;
    logic boot_write_block, boot_segment_absent, general_write_block;
    logic config_write_block, alt_vector_table_enable, two_speed_startup;
    logic deadman_enable, deadman_sw_disable_locked, device_option_reserved_ok;
    logic [`CWD_IDX_W-1:0] nvm_index;
    logic [`CWD_WORD_W-1:0] nvm_data;
    logic [`CWD_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [`CWD_PAGE_W-1:0] boot_page_limit, first_general_page;
    cwd_sec_level_t boot_protect_level, general_protect_level;
    cwd_sec_level_t config_protect_level;
    cwd_osc_src_t initial_osc_select, startup_osc_select;
    cwd_posc_mode_t primary_osc_mode;
    logic [2*`CWD_CNT_HALF_W-1:0] deadman_instr_count;
    logic [`CWD_WORD_W-1:0] words [`CWD_NUM_WORDS];
    logic [`CWD_ADDR_W-1:0] offs [`CWD_NUM_WORDS];
    logic [`CWD_WORD_W-1:0] masks [`CWD_NUM_WORDS];
    logic [3:0] latency;
    int bad_count = 0;
    int check_count = 0;
    cwd_config_decoder i_cwd_config_decoder (.clk, .rst_n, .nvm_req,
        .nvm_index, .nvm_valid, .nvm_data, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .config_ready, .boot_write_block,
        .boot_protect_level, .boot_segment_absent, .boot_page_limit,
        .first_general_page, .general_write_block, .general_protect_level,
        .config_write_block, .config_protect_level, .alt_vector_table_enable,
        .initial_osc_select, .two_speed_startup, .startup_osc_select,
        .primary_osc_mode, .deadman_instr_count, .deadman_enable,
        .deadman_sw_disable_locked, .device_option_reserved_ok,
        .osc_selected_ready);
    cwd_nvm_model i_cwd_nvm_model (.clk, .rst_n, .nvm_req, .nvm_index,
        .nvm_valid, .nvm_data, .words, .latency);
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rd(input logic [23:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    function automatic cwd_sec_level_t lv2(input logic [1:0] v);
        return v == 2'b11 ? CWD_SEC_NONE
            : (v == 2'b10 ? CWD_SEC_STANDARD : CWD_SEC_HIGH);
    endfunction
    function automatic cwd_sec_level_t lv3(input logic [2:0] v);
        return v == 3'h7 ? CWD_SEC_NONE : (v == 3'h6 ? CWD_SEC_STANDARD
            : (v[2] ? CWD_SEC_ENHANCED : CWD_SEC_HIGH));
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic run(input logic [2:0] k);
        logic [12:0] pg;
        int n;
        pg = {10'h3FF, k};
        // option bit 2 always one, page limit holds an inverted page
        words = '{{8'h3C, k[1], 4'h0, k, k[2], k[1:0], k[1], k[2], k[2:1],
            k[0]}, {11'h155, pg}, {16'hF0F0, k[0], 4'hA, k},
            {22'h2AAAA, k[1:0]}, {8'h77, 8'hC3, 5'h00, k},
            {8'h11, 8'h5E, k, 5'h1F}, {23'h12345, k[1]},
            {20'hABCDE, k[0], 1'b1, 2'b10},
            {16'hFFFF, k[0], k, 1'b0, k}};
        latency = {2'b00, k[1:0]} + 4'h1;
        @(posedge clk);
        rst_n <= 1'b0;
        osc_selected_ready <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (config_ready !== 1'b1 && n < 300);
        if (n >= 300)
        begin
            bad_count++;
            $display("ERROR at %0t: load timed out", $time);
            return;
        end
        chk(boot_write_block, !k[0]);
        chk(boot_protect_level, lv2(k[2:1]));
        chk(boot_segment_absent, k[2]);
        chk(boot_page_limit, pg);
        chk(first_general_page, k[2] ? 13'h0000 : {~pg});
        chk(general_write_block, !k[1]);
        chk(general_protect_level, lv2(k[1:0]));
        chk(config_write_block, !k[2]);
        chk(config_protect_level, lv3(k));
        chk(alt_vector_table_enable, !k[1]);
        chk(initial_osc_select, k);
        chk(two_speed_startup, k[0]);
        chk(startup_osc_select, k[0] ? 3'h0 : k);
        chk(primary_osc_mode, k[1:0]);
        chk(deadman_instr_count, {8'h5E, k, 5'h1F, 8'hC3, 5'h00, k});
        chk({deadman_enable, deadman_sw_disable_locked}, {2{k[1]}});
        chk(device_option_reserved_ok, 1'b1);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= `CWD_OFS_SEC;
        reg_wdata <= 32'h0;
        @(posedge clk);
        reg_wr <= 1'b0;
        for (n = 0; n < `CWD_NUM_WORDS; n++)
            rd(offs[n], {8'h00, words[n] | ~masks[n]});
        rd(24'h0157C8, 32'h0);
        rd(`CWD_OFS_STATUS, {25'h0, k[0], 6'h31});
        @(posedge clk);
        osc_selected_ready <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(startup_osc_select, k);
        rd(`CWD_OFS_STATUS, 32'h00000031);
        $display("test run %0d done", k);
    endtask
    initial
    begin
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = '0;
        latency = 4'h1;
        offs = '{`CWD_OFS_SEC, `CWD_OFS_BOOT_PAGE_LIMIT, `CWD_OFS_OSCSEL, `CWD_OFS_OSC,
            `CWD_OFS_CNTL, `CWD_OFS_CNTH, `CWD_OFS_DMT, `CWD_OFS_DEVOPT,
            `CWD_OFS_ALTREG};
        masks = '{`CWD_MASK_SEC, `CWD_MASK_BOOT_PAGE_LIMIT, `CWD_MASK_OSCSEL,
            `CWD_MASK_OSC, `CWD_MASK_CNT, `CWD_MASK_CNT, `CWD_MASK_DMT,
            `CWD_MASK_DEVOPT, `CWD_MASK_ALTREG};
        for (int i = 0; i < 8; i++)
            run(i[2:0]);
        wrap_up();
    end
endmodule // test_cwd_config_decoder
`default_nettype wire
